// ---- nfcb_consts.vh ----
// Purpose: Constants for the NAND flash sequencer with parity check.
// Assumes: Included by nfcb_top.v only.
// Notes: Offsets are APB byte addresses; cycle counts assume a 10 MHz clk.
`ifndef NFCB_CONSTS_VH
`define NFCB_CONSTS_VH
// Register byte offsets.
`define NFCB_OFS_CTRL 8'h00
`define NFCB_OFS_CFG 8'h04
`define NFCB_OFS_CMD 8'h08
`define NFCB_OFS_ADDR0 8'h0C
`define NFCB_OFS_ADDR1 8'h10
`define NFCB_OFS_DELAY 8'h14
`define NFCB_OFS_CS 8'h18
`define NFCB_OFS_DMA 8'h1C
`define NFCB_OFS_META 8'h20
`define NFCB_OFS_STAT 8'h24
`define NFCB_OFS_DATA 8'h28
// Operation codes in CTRL[7:4].
`define NFCB_OP_READ 4'h0
`define NFCB_OP_CREAD 4'h1
`define NFCB_OP_RREAD 4'h2
`define NFCB_OP_PROG 4'h3
`define NFCB_OP_CPROG 4'h4
`define NFCB_OP_RPROG 4'h5
`define NFCB_OP_SCMD 4'h8
`define NFCB_OP_SADDR 4'h9
`define NFCB_OP_SRD 4'hA
`define NFCB_OP_SWR 4'hB
// Status bit positions.
`define NFCB_ST_BUSY 0
`define NFCB_ST_DONE 1
`define NFCB_ST_UNCOR 2
`define NFCB_ST_ERASED 3
`define NFCB_ST_CFGERR 4
// Limits and sizes.
`define NFCB_META_MAX 6'd32
`define NFCB_SEC_SMALL 11'd512
`define NFCB_SEC_LARGE 11'd1024
`define NFCB_SYN_POLY 16'h1021
// Wait after a busy-inducing command before sampling ready: 200 ns at
// 10 MHz, rounded up to whole clocks and sized to the delay counter.
`define NFCB_TWB_CYC 8'h02
`endif

// ---- nfcb_top.v ----
// Purpose: NAND flash page sequencer with DMA over AXI and APB registers.
// Assumes: Flash inputs synchronous to clk; one flash cycle is two clks.
// Notes: Parity is a 16-bit code per sector, stored right after it.
//
// What this block does
// - Drives 8/16-bit flash, pages of 512 bytes up to 16 KB.
// - Strength field 4/8/16 per 512 B, 24/32/40/48 per 1 KB, range-checked only; the code stays 16-bit.
// - Code covers user data, user plus spare_metadata, or nothing.
// - Covered spare_metadata limited to 32 bytes; uncovered up to 252 bytes.
// - Sequences read, program, cache and random ops, up to four pages.
// - Status read issued by hardware after each page program.
// - Single command, address or data phase triggered by software.
// - Up to sixteen sector transfers per page operation.
// - Erased pages detected during page reads.
// - Random ops issue own command and address; one page per trigger.
// - Parity bytes interleaved after each user data sector.
// - Flash cycle runs at half the module clock.
// - Sixteen chip selects and two ready_busy_line inputs.
// - Programmable 8-bit delays before data after command or address.
// - Read data written to system memory before its parity is checked.
// - Four or five address cycles selectable.
// - Sixteen-bit flash from two 8-bit chips in parallel.
// - Software or hardware may issue command and address phases.
// - bose_chaudhuri_code datapath takes eight bits per step.
// - Page data moves to and from memory as an AXI master.
`timescale 1ns/1ns
`include "nfcb_consts.vh"
module nfcb_top (
  input wire clk, // Module clock.
  input wire rst_b, // Asynchronous reset, active low.
  input wire psel, // APB select.
  input wire penable, // APB enable.
  input wire pwrite, // APB direction.
  input wire [7:0] paddr, // APB byte address.
  input wire [31:0] pwdata, // APB write data.
  output reg [31:0] prdata, // APB read data.
  output reg pready, // APB ready.
  output reg pslverr, // APB error on unmapped address.
  output reg [31:0] m_awaddr, // AXI write address.
  output reg m_awvalid, // AXI write address valid.
  input wire m_awready, // AXI write address ready.
  output reg [31:0] m_wdata, // AXI write data.
  output reg [3:0] m_wstrb, // AXI write strobes.
  output reg m_wvalid, // AXI write valid.
  input wire m_wready, // AXI write ready.
  input wire m_bvalid, // AXI response valid.
  output reg m_bready, // AXI response ready.
  output reg [31:0] m_araddr, // AXI read address.
  output reg m_arvalid, // AXI read address valid.
  input wire m_arready, // AXI read address ready.
  input wire [31:0] m_rdata, // AXI read data.
  input wire m_rvalid, // AXI read valid.
  output reg m_rready, // AXI read ready.
  output reg [15:0] nf_ce_b, // Flash chip selects, active low.
  output reg nf_cle, // Command latch enable.
  output reg nf_ale, // Address latch enable.
  output reg nf_we_b, // Write strobe, active low.
  output reg nf_re_b, // Read strobe, active low.
  output reg [15:0] nf_dq_o, // Flash data out.
  output reg nf_dq_oe, // Flash data drive enable.
  input wire [15:0] nf_dq_i, // Flash data in.
  input wire [1:0] ready_busy_line // Flash ready, high when ready.
);

////////////////////////////////////////////////////////////////////////////
localparam S_IDLE = 4'd0;
localparam S_CMD = 4'd1;
localparam S_ADDR = 4'd2;
localparam S_WRB = 4'd3;
localparam S_DLY = 4'd4;
localparam S_XFER = 4'd5;
localparam S_PAR = 4'd6;
localparam S_AXW = 4'd7;
localparam S_AXR = 4'd8;
localparam S_STAT = 4'd9;
localparam S_DONE = 4'd10;

// Reset release through two flops.
reg rst_s1_r, rst_s2_r;
always @(posedge clk or negedge rst_b) begin
  if (!rst_b) begin
    rst_s1_r <= 1'b0;
    rst_s2_r <= 1'b0;
  end else begin
    rst_s1_r <= 1'b1;
    rst_s2_r <= rst_s1_r;
  end
end
wire rst_n = rst_s2_r;

reg [31:0] cfg_r, addr0_r, addr1_r, dma_r;
reg [15:0] delay_r;
reg [7:0] cmd_r, data_r, fstat_r, meta_r;
reg [4:0] cs_r;
reg done_r, uncor_r, erased_r, cfgerr_r;
reg [3:0] state_r, op_r, dret_r;
reg ph_r, par_r, have_r, awd_r, wd_r, mism_r, allff_r;
reg [1:0] ci_r, page_r;
reg [2:0] aidx_r;
reg [4:0] sec_r;
reg [10:0] bcnt_r;
reg [7:0] dly_r;
reg [23:0] row_r;
reg [31:0] ptr_r, pack_r;
reg [15:0] syn_r;

// Configuration fields.
wire bus16 = cfg_r[0];
wire addr5 = cfg_r[1];
wire [1:0] ecc_mode = cfg_r[3:2];
wire [2:0] strength = cfg_r[6:4];
wire sec1k = cfg_r[7];
wire [1:0] npage = cfg_r[9:8];
wire [3:0] nsec = cfg_r[13:10];
wire dual8 = cfg_r[14];
wire is_prog = (op_r == `NFCB_OP_PROG) || (op_r == `NFCB_OP_CPROG) ||
               (op_r == `NFCB_OP_RPROG);
wire is_rand = (op_r == `NFCB_OP_RREAD) || (op_r == `NFCB_OP_RPROG);
wire in_meta = (sec_r == {1'b0, nsec} + 5'd1);
wire str_ok = sec1k ? (strength >= 3'd3 && strength <= 3'd6)
                    : (strength <= 3'd2);
wire meta_bad = (ecc_mode == 2'd2) && (meta_r > {2'b00, `NFCB_META_MAX});
wire ecc_on = in_meta ? (ecc_mode == 2'd2) : (ecc_mode != 2'd0);
wire [10:0] sec_len = in_meta ? {3'b000, meta_r[7:2], 2'b00} :
                      (sec1k ? `NFCB_SEC_LARGE : `NFCB_SEC_SMALL);
wire [10:0] bstep = bus16 ? 11'd2 : 11'd1;
wire [10:0] bnext = bcnt_r + bstep;
wire rb_ok = ready_busy_line[cs_r[4]];

// Command bytes for each page operation and stage.
reg [7:0] cur_cmd;
always @* begin
  cur_cmd = cmd_r;
  if (ci_r == 2'd2) begin
    cur_cmd = 8'h70;
  end else begin
    case (op_r)
      `NFCB_OP_READ: cur_cmd = ci_r[0] ? 8'h30 : 8'h00;
      `NFCB_OP_CREAD: cur_cmd = ci_r[0] ? 8'h31 : 8'h00;
      `NFCB_OP_RREAD: cur_cmd = ci_r[0] ? 8'hE0 : 8'h05;
      `NFCB_OP_PROG: cur_cmd = ci_r[0] ? 8'h10 : 8'h80;
      `NFCB_OP_CPROG: cur_cmd = ci_r[0] ? 8'h15 : 8'h80;
      `NFCB_OP_RPROG: cur_cmd = ci_r[0] ? 8'h10 : 8'h85;
      default: cur_cmd = cmd_r;
    endcase
  end
end

wire [2:0] alast = is_rand ? 3'd1 : (addr5 ? 3'd4 : 3'd3);
wire [39:0] abytes = {row_r, addr0_r[15:0]};
wire [7:0] cur_addr = (op_r == `NFCB_OP_SADDR) ? addr0_r[7:0] :
                      abytes[{aidx_r, 3'b000} +: 8];

// Eight-bit step of the check code.
function [15:0] nfcb_syn;
  input [15:0] s;
  input [7:0] b;
  integer i;
  reg [15:0] t;
  begin
    t = s ^ {b, 8'h00};
    for (i = 0; i < 8; i = i + 1) begin
      t = t[15] ? ({t[14:0], 1'b0} ^ `NFCB_SYN_POLY) : {t[14:0], 1'b0};
    end
    nfcb_syn = t;
  end
endfunction

wire [15:0] syn1 = nfcb_syn(syn_r, bus16 ? nf_dq_i[7:0] : nf_dq_i[7:0]);
wire [15:0] syn_rd = bus16 ? nfcb_syn(syn1, nf_dq_i[15:8]) : syn1;
wire [15:0] syn_wr0 = nfcb_syn(syn_r, pack_r[7:0]);
wire [15:0] syn_wr = bus16 ? nfcb_syn(syn_wr0, pack_r[15:8]) : syn_wr0;
wire rd_ff = bus16 ? (nf_dq_i == 16'hFFFF) : (nf_dq_i[7:0] == 8'hFF);

////////////////////////////////////////////////////////////////////////////
// APB slave: one wait state, writes land at the edge pready is seen.
wire acc = psel && penable && pready;
wire wr = acc && pwrite;
wire start = wr && (paddr == `NFCB_OFS_CTRL) && pwdata[0] &&
             (state_r == S_IDLE);
reg ev_done, ev_uncor, ev_erased;
always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    pready <= 1'b0;
    pslverr <= 1'b0;
    prdata <= 32'h0000_0000;
    cfg_r <= 32'h0000_0000;
    addr0_r <= 32'h0000_0000;
    addr1_r <= 32'h0000_0000;
    dma_r <= 32'h0000_0000;
    delay_r <= 16'h0000;
    cmd_r <= 8'h00;
    meta_r <= 8'h00;
    cs_r <= 5'h00;
    done_r <= 1'b0;
    uncor_r <= 1'b0;
    erased_r <= 1'b0;
    cfgerr_r <= 1'b0;
  end else begin
    pready <= psel && penable && !pready;
    pslverr <= psel && penable && !pready && (paddr > `NFCB_OFS_DATA ||
               paddr[1:0] != 2'b00);
    if (psel && penable && !pready) begin
      case (paddr)
        `NFCB_OFS_CFG: prdata <= cfg_r;
        `NFCB_OFS_CMD: prdata <= {24'h00_0000, cmd_r};
        `NFCB_OFS_ADDR0: prdata <= addr0_r;
        `NFCB_OFS_ADDR1: prdata <= addr1_r;
        `NFCB_OFS_DELAY: prdata <= {16'h0000, delay_r};
        `NFCB_OFS_CS: prdata <= {27'h000_0000, cs_r};
        `NFCB_OFS_DMA: prdata <= dma_r;
        `NFCB_OFS_META: prdata <= {24'h00_0000, meta_r};
        `NFCB_OFS_STAT: prdata <= {16'h0000, fstat_r, 3'b000, cfgerr_r,
                                   erased_r, uncor_r, done_r,
                                   (state_r != S_IDLE)};
        `NFCB_OFS_DATA: prdata <= {24'h00_0000, data_r};
        default: prdata <= 32'h0000_0000;
      endcase
    end
    if (wr && state_r == S_IDLE) begin
      case (paddr)
        `NFCB_OFS_CFG: cfg_r <= pwdata;
        `NFCB_OFS_CMD: cmd_r <= pwdata[7:0];
        `NFCB_OFS_ADDR0: addr0_r <= pwdata;
        `NFCB_OFS_ADDR1: addr1_r <= pwdata;
        `NFCB_OFS_DELAY: delay_r <= pwdata[15:0];
        `NFCB_OFS_CS: cs_r <= pwdata[4:0];
        `NFCB_OFS_DMA: dma_r <= pwdata;
        `NFCB_OFS_META: meta_r <= pwdata[7:0];
        default: cs_r <= cs_r;
      endcase
    end
    // Sticky flags: a hardware set in the same cycle beats the clear.
    if (wr && paddr == `NFCB_OFS_STAT) begin
      done_r <= (done_r && !pwdata[`NFCB_ST_DONE]) || ev_done;
      uncor_r <= (uncor_r && !pwdata[`NFCB_ST_UNCOR]) || ev_uncor;
      erased_r <= (erased_r && !pwdata[`NFCB_ST_ERASED]) || ev_erased;
      cfgerr_r <= cfgerr_r && !pwdata[`NFCB_ST_CFGERR];
    end else begin
      done_r <= done_r || ev_done;
      uncor_r <= uncor_r || ev_uncor;
      erased_r <= erased_r || ev_erased;
      cfgerr_r <= cfgerr_r || (start && (meta_bad || !str_ok));
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// Sequencer. Each flash cycle: phase 0 drives strobe low, phase 1 high.
// Half-rate strobes
always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    state_r <= S_IDLE;
    op_r <= 4'h0;
    dret_r <= S_IDLE;
    ph_r <= 1'b0;
    par_r <= 1'b0;
    have_r <= 1'b0;
    awd_r <= 1'b0;
    wd_r <= 1'b0;
    mism_r <= 1'b0;
    allff_r <= 1'b1;
    ci_r <= 2'd0;
    page_r <= 2'd0;
    aidx_r <= 3'd0;
    sec_r <= 5'd0;
    bcnt_r <= 11'd0;
    dly_r <= 8'h00;
    row_r <= 24'h00_0000;
    ptr_r <= 32'h0000_0000;
    pack_r <= 32'h0000_0000;
    syn_r <= 16'h0000;
    data_r <= 8'h00;
    fstat_r <= 8'h00;
    ev_done <= 1'b0;
    ev_uncor <= 1'b0;
    ev_erased <= 1'b0;
    nf_ce_b <= 16'hFFFF;
    nf_cle <= 1'b0;
    nf_ale <= 1'b0;
    nf_we_b <= 1'b1;
    nf_re_b <= 1'b1;
    nf_dq_o <= 16'h0000;
    nf_dq_oe <= 1'b0;
    m_awaddr <= 32'h0000_0000;
    m_awvalid <= 1'b0;
    m_wdata <= 32'h0000_0000;
    m_wstrb <= 4'h0;
    m_wvalid <= 1'b0;
    m_bready <= 1'b0;
    m_araddr <= 32'h0000_0000;
    m_arvalid <= 1'b0;
    m_rready <= 1'b0;
  end else begin
    ev_done <= 1'b0;
    ev_uncor <= 1'b0;
    ev_erased <= 1'b0;
    m_bready <= 1'b1;
    m_rready <= 1'b1;
    case (state_r)
      S_IDLE: begin
        nf_ce_b <= 16'hFFFF;
        if (start && !meta_bad && str_ok) begin
          nf_ce_b <= ~((16'h0001 << cs_r[3:0]) |
                       (dual8 ? (16'h0001 << (cs_r[3:0] ^ 4'h1)) : 16'h0000));
          op_r <= pwdata[7:4];
          ci_r <= 2'd0;
          aidx_r <= 3'd0;
          page_r <= 2'd0;
          sec_r <= 5'd0;
          bcnt_r <= 11'd0;
          syn_r <= 16'h0000;
          mism_r <= 1'b0;
          allff_r <= 1'b1;
          have_r <= 1'b0;
          ph_r <= 1'b0;
          row_r <= {addr1_r[7:0], addr0_r[31:16]};
          ptr_r <= dma_r;
          case (pwdata[7:4])
            `NFCB_OP_SADDR: state_r <= S_ADDR;
            `NFCB_OP_SRD: begin
              dly_r <= delay_r[7:0];
              dret_r <= S_STAT;
              state_r <= S_DLY;
            end
            `NFCB_OP_SWR: state_r <= S_XFER;
            default: state_r <= S_CMD;
          endcase
        end
      end
      S_CMD: begin
        ph_r <= !ph_r;
        nf_dq_oe <= 1'b1;
        nf_cle <= !ph_r;
        nf_we_b <= ph_r;
        nf_dq_o <= {8'h00, cur_cmd};
        if (ph_r) begin
          nf_dq_oe <= 1'b0;
          if (op_r == `NFCB_OP_SCMD) begin
            state_r <= S_DONE;
          end else if (ci_r == 2'd0) begin
            state_r <= S_ADDR;
          end else if (ci_r == 2'd2) begin
            dly_r <= delay_r[7:0];
            dret_r <= S_STAT;
            state_r <= S_DLY;
          end else if (op_r == `NFCB_OP_RREAD) begin
            dly_r <= delay_r[7:0];
            dret_r <= S_XFER;
            state_r <= S_DLY;
          end else begin
            dly_r <= `NFCB_TWB_CYC;
            state_r <= S_WRB;
          end
        end
      end
      S_ADDR: begin
        ph_r <= !ph_r;
        nf_dq_oe <= 1'b1;
        nf_ale <= !ph_r;
        nf_we_b <= ph_r;
        nf_dq_o <= {8'h00, cur_addr};
        if (ph_r) begin
          nf_dq_oe <= 1'b0;
          aidx_r <= aidx_r + 3'd1;
          if (op_r == `NFCB_OP_SADDR) begin
            state_r <= S_DONE;
          end else if (aidx_r == alast) begin
            aidx_r <= 3'd0;
            if (is_prog) begin
              dly_r <= delay_r[15:8];
              dret_r <= S_XFER;
              state_r <= S_DLY;
            end else begin
              ci_r <= 2'd1;
              state_r <= S_CMD;
            end
          end
        end
      end
      S_WRB: begin
        if (dly_r != 8'h00) begin
          dly_r <= dly_r - 8'h01;
        end else if (rb_ok) begin
          if (is_prog) begin
            ci_r <= 2'd2;
            state_r <= S_CMD;
          end else begin
            dly_r <= delay_r[7:0];
            dret_r <= S_XFER;
            state_r <= S_DLY;
          end
        end
      end
      S_DLY: begin
        dly_r <= dly_r - 8'h01;
        if (dly_r == 8'h00) begin
          state_r <= dret_r;
        end
      end
      S_XFER: begin
        if (op_r == `NFCB_OP_SWR) begin
          ph_r <= !ph_r;
          nf_dq_oe <= 1'b1;
          nf_we_b <= ph_r;
          nf_dq_o <= {8'h00, addr1_r[31:24]};
          if (ph_r) begin
            nf_dq_oe <= 1'b0;
            state_r <= S_DONE;
          end
        end else if (bcnt_r == sec_len) begin
          bcnt_r <= 11'd0;
          par_r <= 1'b0;
          state_r <= ecc_on ? S_PAR : S_XFER;
          if (!ecc_on) begin
            sec_r <= sec_r + 5'd1;
          end
          if (!ecc_on && (in_meta || (sec_r == {1'b0, nsec} &&
              meta_r[7:2] == 6'd0) || is_rand)) begin
            sec_r <= 5'd0;
            state_r <= S_DONE;
          end
        end else if (is_prog && !have_r) begin
          m_araddr <= ptr_r;
          m_arvalid <= 1'b1;
          state_r <= S_AXR;
        end else begin
          ph_r <= !ph_r;
          nf_dq_oe <= is_prog;
          nf_we_b <= !(is_prog && !ph_r);
          nf_re_b <= !(!is_prog && !ph_r);
          nf_dq_o <= bus16 ? pack_r[15:0] : {8'h00, pack_r[7:0]};
          if (ph_r) begin
            nf_dq_oe <= 1'b0;
            bcnt_r <= bnext;
            if (is_prog) begin
              syn_r <= syn_wr;
              pack_r <= bus16 ? {16'h0000, pack_r[31:16]} :
                                {8'h00, pack_r[31:8]};
              have_r <= (bnext[1:0] != 2'b00);
            end else begin
              syn_r <= syn_rd;
              allff_r <= allff_r && rd_ff;
              pack_r <= bus16 ? {nf_dq_i, pack_r[31:16]} :
                                {nf_dq_i[7:0], pack_r[31:8]};
              if (bnext[1:0] == 2'b00) begin
                state_r <= S_AXW;
                awd_r <= 1'b0;
                wd_r <= 1'b0;
              end
            end
          end
        end
      end
      S_PAR: begin
        ph_r <= !ph_r;
        nf_dq_oe <= is_prog;
        nf_we_b <= !(is_prog && !ph_r);
        nf_re_b <= !(!is_prog && !ph_r);
        nf_dq_o <= bus16 ? syn_r : {8'h00, (par_r ? syn_r[15:8] :
                                                    syn_r[7:0])};
        if (ph_r) begin
          nf_dq_oe <= 1'b0;
          par_r <= 1'b1;
          if (!is_prog) begin
            allff_r <= allff_r && rd_ff;
            if (bus16) begin
              mism_r <= mism_r || (nf_dq_i != syn_r);
            end else begin
              mism_r <= mism_r || (nf_dq_i[7:0] !=
                        (par_r ? syn_r[15:8] : syn_r[7:0]));
            end
          end
          if (bus16 || par_r) begin
            syn_r <= 16'h0000;
            state_r <= S_XFER;
            sec_r <= sec_r + 5'd1;
            if (in_meta || is_rand || (sec_r == {1'b0, nsec} &&
                meta_r[7:2] == 6'd0)) begin
              sec_r <= 5'd0;
              state_r <= S_DONE;
            end
          end
        end
      end
      S_AXW: begin
        m_awaddr <= ptr_r;
        m_wdata <= pack_r;
        m_wstrb <= 4'hF;
        m_awvalid <= !awd_r && !(m_awvalid && m_awready);
        m_wvalid <= !wd_r && !(m_wvalid && m_wready);
        if (m_awvalid && m_awready) begin
          awd_r <= 1'b1;
        end
        if (m_wvalid && m_wready) begin
          wd_r <= 1'b1;
        end
        if (m_bvalid && m_bready) begin
          ptr_r <= ptr_r + 32'h0000_0004;
          m_awvalid <= 1'b0;
          m_wvalid <= 1'b0;
          state_r <= S_XFER;
        end
      end
      S_AXR: begin
        if (m_arvalid && m_arready) begin
          m_arvalid <= 1'b0;
        end
        if (m_rvalid && m_rready) begin
          pack_r <= m_rdata;
          have_r <= 1'b1;
          ptr_r <= ptr_r + 32'h0000_0004;
          state_r <= S_XFER;
        end
      end
      S_STAT: begin
        ph_r <= !ph_r;
        nf_re_b <= ph_r;
        if (ph_r) begin
          if (op_r == `NFCB_OP_SRD) begin
            data_r <= nf_dq_i[7:0];
          end else begin
            fstat_r <= nf_dq_i[7:0];
          end
          state_r <= S_DONE;
        end
      end
      default: begin
        // Page end: program issues its confirm, reads close the page.
        if (is_prog && ci_r == 2'd0) begin
          ci_r <= 2'd1;
          state_r <= S_CMD;
        end else begin
          if (!is_prog && op_r <= `NFCB_OP_RREAD) begin
            ev_erased <= allff_r;
            ev_uncor <= mism_r && !allff_r;
          end
          mism_r <= 1'b0;
          allff_r <= 1'b1;
          if (op_r <= `NFCB_OP_RPROG && !is_rand && page_r != npage) begin
            page_r <= page_r + 2'd1;
            row_r <= row_r + 24'h00_0001;
            ci_r <= 2'd0;
            state_r <= S_CMD;
          end else begin
            ev_done <= 1'b1;
            nf_ce_b <= 16'hFFFF;
            state_r <= S_IDLE;
          end
        end
      end
    endcase
  end
end
endmodule

// ---- nfcb_checker.sv ----
// Purpose: Port checker for the flash sequencer.
// Assumes: Bound to nfcb_top; one clock domain.
// Notes: Flash strobes are low for one clk only.
`timescale 1ns/1ns
module nfcb_checker (
  input wire clk, // Clock.
  input wire rst_b, // Reset.
  input wire psel, // Select.
  input wire penable, // Enable.
  input wire pready, // Ready.
  input wire pslverr, // Error.
  input wire m_wvalid, // Write valid.
  input wire [3:0] m_wstrb, // Strobes.
  input wire nf_cle, // Command latch.
  input wire nf_ale, // Address latch.
  input wire nf_we_b, // Write strobe.
  input wire nf_re_b, // Read strobe.
  input wire nf_dq_oe // Drive enable.
);
  // All checks share the module clock and the raw reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait)
    else $error("slow answer");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse)
    else $error("ready too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err)
    else $error("stray error");
  property p_cle; nf_cle |-> !nf_ale; endproperty
  a_cle: assert property (p_cle)
    else $error("both latches");
  property p_we; $fell(nf_we_b) |=> $rose(nf_we_b); endproperty
  a_we: assert property (p_we)
    else $error("long write strobe");
  property p_re; $fell(nf_re_b) |=> $rose(nf_re_b); endproperty
  a_re: assert property (p_re)
    else $error("long read strobe");
  property p_rd; !nf_re_b |-> !nf_dq_oe && nf_we_b; endproperty
  a_rd: assert property (p_rd)
    else $error("drive during read");
  property p_strb; m_wvalid |-> m_wstrb == 4'hf; endproperty
  a_strb: assert property (p_strb)
    else $error("partial strobe");
  c_cmd: cover property (nf_cle && !nf_we_b);
  c_read: cover property (!nf_re_b);
  c_dma: cover property (m_wvalid);
endmodule
bind nfcb_top nfcb_checker i_chk (.clk(clk), .rst_b(rst_b), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr),
  .m_wvalid(m_wvalid), .m_wstrb(m_wstrb), .nf_cle(nf_cle),
  .nf_ale(nf_ale), .nf_we_b(nf_we_b), .nf_re_b(nf_re_b),
  .nf_dq_oe(nf_dq_oe));

// ---- nfcb_flash_model.sv ----
// Purpose: Behavioural flash die on chip select zero.
// Assumes: Array is erased; status byte is E0.
// Notes: Idle bus toggles so a stale value never passes.
`timescale 1ns/1ns
module nfcb_flash_model (
  input wire clk, // Clock.
  input wire [15:0] ce_b, // Selects.
  input wire cle, // Command latch.
  input wire ale, // Address latch.
  input wire we_b, // Write strobe.
  input wire re_b, // Read strobe.
  input wire [15:0] dq, // Data from host.
  output reg [15:0] q, // Data to host.
  output wire [1:0] rdy, // Ready lines.
  output reg [7:0] cmd, // Last command.
  output reg [3:0] adr // Address cycles.
);
  reg [7:0] bsy_r = 8'h00;
  initial cmd = 8'hff;
  initial adr = 4'h0;
  assign rdy = (bsy_r == 8'h00) ? 2'b11 : 2'b00;
  always @(posedge clk) begin
    if (bsy_r != 8'h00)
      bsy_r <= bsy_r - 8'h01;
    if (!ce_b[0] && !we_b && cle) begin
      cmd <= dq[7:0];
      if (dq[7:0] == 8'h00 || dq[7:0] == 8'h80)
        adr <= 4'h0;
      if (dq[7:0] == 8'h30 || dq[7:0] == 8'h10)
        bsy_r <= 8'h14;
    end
    if (!ce_b[0] && !we_b && ale)
      adr <= adr + 4'h1;
  end
  // Read data only while the strobe is low.
  always @* begin
    if (re_b || ce_b[0])
      q = 16'h5a5a ^ {16{clk}};
    else if (cmd == 8'h70)
      q = 16'h00e0;
    else
      q = 16'hffff;
  end
endmodule

// ---- nand_flash_controller_bch_tb.sv ----
// Purpose: Register-level tests of the flash sequencer.
// Assumes: Memory answers every beat one clk later.
// Notes: Single-sector pages keep the run short.
`timescale 1ns/1ns
module nand_flash_controller_bch_tb;
  reg clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0000_0000, rdat, rd = 32'h0000_0000;
  reg rerr, bv = 1'b0, rv = 1'b0;
  wire [31:0] prdata, ara;
  wire pready, pslverr, wv, arv, cle, ale, we_b, re_b;
  wire [15:0] ce_b, dq_o, q;
  wire [1:0] rdy;
  wire [7:0] cmd;
  wire [3:0] adr;
  integer mismatches = 0, comparisons = 0;
  nfcb_top i_dut (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .m_awaddr(),
    .m_awvalid(), .m_awready(1'b1), .m_wdata(), .m_wstrb(),
    .m_wvalid(wv), .m_wready(1'b1), .m_bvalid(bv), .m_bready(),
    .m_araddr(ara), .m_arvalid(arv), .m_arready(1'b1), .m_rdata(rd),
    .m_rvalid(rv), .m_rready(), .nf_ce_b(ce_b), .nf_cle(cle),
    .nf_ale(ale), .nf_we_b(we_b), .nf_re_b(re_b), .nf_dq_o(dq_o),
    .nf_dq_oe(), .nf_dq_i(q), .ready_busy_line(rdy));
  nfcb_flash_model i_fm (.clk(clk), .ce_b(ce_b), .cle(cle), .ale(ale),
    .we_b(we_b), .re_b(re_b), .dq(dq_o), .q(q), .rdy(rdy), .cmd(cmd),
    .adr(adr));
  initial forever #50 clk = ~clk;
  // Memory side answers each beat one clk later.
  always @(posedge clk) begin
    bv <= wv && !bv;
    rv <= arv && !rv;
    rd <= ara;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t: %h not %h", $time, got, exp);
      end
    end
  endtask
  // One register access; held until ready is seen at an edge.
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge clk) psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 50) begin
        @(posedge clk);
        n = n + 1;
      end
      // A missing answer counts as a mismatch.
      if (pready !== 1'b1)
        mismatches = mismatches + 1;
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // Polling status stops at idle with done set.
  task wait_done;
    integer n;
    begin
      n = 0;
      rdat = 32'h0000_0001;
      while (rdat[1:0] !== 2'b10 && n < 2000) begin
        apb(1'b0, 8'h24, 32'h0000_0000);
        n = n + 1;
      end
      // An operation that never finishes counts as a mismatch.
      if (rdat[1:0] !== 2'b10)
        mismatches = mismatches + 1;
    end
  endtask
  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // Hang guard well beyond the longest page transfer.
  initial begin
    repeat (60000) @(posedge clk);
    mismatches = mismatches + 1;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, 8'h3c, 32'h0000_0000);
    chk(rerr, 1);
    chk(rdat, 0);
    apb(1'b1, 8'h04, 32'h0000_0006);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk(rdat[3:0], 4'h6);
    apb(1'b1, 8'h14, 32'h0000_ff00);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk(rdat[15:0], 16'hff00);
    apb(1'b1, 8'h08, 32'h0000_0070);
    apb(1'b1, 8'h00, 32'h0000_0081);
    wait_done;
    chk(cmd, 8'h70);
    apb(1'b1, 8'h00, 32'h0000_00a1);
    wait_done;
    apb(1'b0, 8'h28, 32'h0000_0000);
    chk(rdat[7:0], 8'he0);
    apb(1'b1, 8'h04, 32'h0000_0004);
    apb(1'b1, 8'h1c, 32'h0000_1000);
    apb(1'b1, 8'h00, 32'h0000_0001);
    wait_done;
    chk(rdat[3:2], 2'b10);
    chk(adr, 4);
    apb(1'b1, 8'h04, 32'h0000_0006);
    apb(1'b1, 8'h00, 32'h0000_0031);
    wait_done;
    chk(cmd, 8'h70);
    chk(adr, 5);
    chk(rdat[15:8], 8'he0);
    apb(1'b1, 8'h04, 32'h0000_0008);
    apb(1'b1, 8'h20, 32'h0000_0024);
    apb(1'b1, 8'h00, 32'h0000_0031);
    apb(1'b0, 8'h24, 32'h0000_0000);
    chk(rdat[4], 1);
    apb(1'b1, 8'h24, 32'h0000_0010);
    apb(1'b1, 8'h20, 32'h0000_0020);
    apb(1'b1, 8'h00, 32'h0000_0031);
    wait_done;
    chk(rdat[4], 0);
    apb(1'b1, 8'h00, 32'h0000_0091);
    wait_done;
    chk(adr, 5);
    print_verdict;
  end
endmodule
